// >>> indicator_blink_defs.vh
/*
 * Constants for the indicator source-select, blink and slow-clock block:
 * register addresses, field positions, reset values and timing figures.
 * Assumes the includer uses the macros at the widths given here.
 */
`ifndef INDICATOR_BLINK_DEFS_VH
`define INDICATOR_BLINK_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register addresses
`define ADDR_SLOW_CNT_LOW    16'hA82A
`define ADDR_SLOW_CNT_HIGH   16'hA82B
`define ADDR_IND4_MASK_LOW   16'hA835
`define ADDR_IND4_BLINK      16'hA837
`define ADDR_IND5_MASK_LOW   16'hA838
`define ADDR_IND5_BLINK      16'hA83A
`define ADDR_IND_CONTROL     16'hA83B
`define ADDR_IND4_MASK_EXT   16'hA8F2
`define ADDR_IND5_MASK_EXT   16'hA8F3

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define BLINK_LEN_MSB        3
`define SLOW_HIGH_MSB        7
`define CTL_IND4_FUNC_LSB    9
`define CTL_IND4_DIS_BIT     11
`define CTL_IND5_FUNC_LSB    12
`define CTL_IND5_DIS_BIT     14

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define MASK_RESET           16'h0000
`define BLINK_LEN_RESET      4'h4
`define SLOW_HIGH_RESET      8'hFF
`define SLOW_LOW_RESET       16'hFFFF
`define FUNC_RESET           2'b00
`define DIS_RESET            1'b1

////////////////////////////////////////////////////////////////////////////////
// Function select codes
`define FUNC_OFF             2'b00
`define FUNC_BLINK           2'b01
`define FUNC_STEADY          2'b10
`define FUNC_OPEN_DRAIN      2'b11

////////////////////////////////////////////////////////////////////////////////
// Timing: reference period of the slow-clock divider, in ns, and core rate
`define REF_PERIOD_NS        10
`define CORE_CLK_MHZ         100

`endif

// >>> indicator_blink_properties.sv
/* Checker for the register port, slow tick and pin drive.
   Assumes a bind to indicator_blink_top, one clock domain. */
`timescale 1ns/1ps
module indicator_blink_checker #(
   parameter [23:0] SLOW_CNT_RESET = 24'hFF_FFFF
) (
   input wire I_CORE_CLK,
   input wire I_RST_N,
   input wire [15:0] I_REG_ADDR,
   input wire I_REG_WR,
   input wire [15:0] I_REG_WDATA,
   input wire I_REG_RD,
   input wire [15:0] O_REG_RDATA,
   input wire O_REG_RVALID,
   input wire O_SLOW_TICK,
   input wire [1:0] O_IND_OUT,
   input wire [1:0] O_IND_OE
);
   reg [15:0] ctl_ff;
   // Shadow of the stored control bits, so pin checks need no internal probe
   always @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N)
         ctl_ff <= 16'h4800;
      else if (I_REG_WR && I_REG_ADDR == 16'hA83B)
         ctl_ff <= I_REG_WDATA & 16'h7E00;
   end
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);
   ////////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (I_REG_RD |=> O_REG_RVALID)
      else $error("read not answered");
   a_answer_cause: assert property (O_REG_RVALID |-> $past(I_REG_RD))
      else $error("answer without read");
   a_high_upper_zero: assert property (
      I_REG_RD && I_REG_ADDR == 16'hA82B |=> O_REG_RDATA[15:8] == 8'h00)
      else $error("high count upper bits not zero");
   a_blink_upper_zero: assert property (
      I_REG_RD && (I_REG_ADDR == 16'hA837 || I_REG_ADDR == 16'hA83A) |=> O_REG_RDATA[15:4] == 12'h000)
      else $error("blink upper bits not zero");
   a_tick_single: assert property (
      O_SLOW_TICK && SLOW_CNT_RESET != 24'h00_0000 |=> !O_SLOW_TICK)
      else $error("slow tick wider than one cycle");
   a_drive_disable: assert property (ctl_ff[11] |=> !O_IND_OE[0])
      else $error("disabled pin still driven");
   a_off_dark: assert property (ctl_ff[10:9] == 2'b00 |=> !O_IND_OUT[0])
      else $error("off indicator lit");
   a_drain_low: assert property (ctl_ff[13:12] == 2'b11 |=> !O_IND_OUT[1])
      else $error("open drain drives high");
   c_tick: cover property (O_SLOW_TICK);
   c_drain_on: cover property (O_IND_OE[1] && !O_IND_OUT[1]);
   c_blink: cover property (ctl_ff[10:9] == 2'b01 && $changed(O_IND_OUT[0]));
endmodule // indicator_blink_checker
bind indicator_blink_top indicator_blink_checker #(.SLOW_CNT_RESET(SLOW_CNT_RESET)) i_indicator_blink_checker (
   .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_REG_ADDR(I_REG_ADDR), .I_REG_WR(I_REG_WR),
   .I_REG_WDATA(I_REG_WDATA), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
   .O_REG_RVALID(O_REG_RVALID), .O_SLOW_TICK(O_SLOW_TICK), .O_IND_OUT(O_IND_OUT), .O_IND_OE(O_IND_OE));

// >>> indicator_blink_top.v
/*
 * Indicator four and five source selection, blink timing and slow-clock
 * divider, with their management registers on a simple 16-bit port.
 * Assumes source levels come from logic on I_CORE_CLK and register
 * accesses are single-cycle strobes on the same clock.
 */
// Function
// - Each indicator has extended source enables 32..47, reset to zero.
// - Each indicator has low source enables 0..15, reset to zero.
// - A 4-bit blink length sets slow-clock ticks per on and off phase.
// - Blink length resets to four ticks.
// - Slow clock period is 24-bit count plus one, times 10 ns.
// - Upper 8-bit count part is read-write and resets to all ones.
// - Lower 16-bit count part resets to all ones.
// - Upper eight bits of the high count register ignore writes, read zero.
// - Function select: off, blink when active, steady when active, open drain.
// - Active-low drive enable bit: one disables the pin driver.
`timescale 1ns/1ps
`include "indicator_blink_defs.vh"

module indicator_blink_top #(
   parameter [23:0] SLOW_CNT_RESET = {`SLOW_HIGH_RESET, `SLOW_LOW_RESET}
) (
   input wire I_CORE_CLK,
   input wire I_RST_N,
   input wire [15:0] I_REG_ADDR,
   input wire I_REG_WR,
   input wire [15:0] I_REG_WDATA,
   input wire I_REG_RD,
   input wire [15:0] I_SOURCE_LOW,
   input wire [15:0] I_SOURCE_EXT,
   output reg [15:0] O_REG_RDATA,
   output reg O_REG_RVALID,
   output reg O_SLOW_TICK,
   output wire [1:0] O_IND_OUT,
   output wire [1:0] O_IND_OE
);

   localparam integer NUM_IND = 2;
   // Reference cycles per 10 ns step of the divider, at least one
   localparam integer REF_CYCLES = (`REF_PERIOD_NS * `CORE_CLK_MHZ + 999) / 1000;

   reg [15:0] mask_low_ff [0:NUM_IND-1];
   reg [15:0] mask_ext_ff [0:NUM_IND-1];
   reg [3:0] blink_len_ff [0:NUM_IND-1];
   reg [1:0] func_ff [0:NUM_IND-1];
   reg dis_ff [0:NUM_IND-1];
   reg [7:0] slow_high_ff;
   reg [15:0] slow_low_ff;
   reg [23:0] div_cnt_ff;
   reg [7:0] ref_cnt_ff;
   reg [15:0] nxt_rdata;
   wire [23:0] slow_count;
   wire ref_step;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helper used by the per-indicator write path; the read mux decodes addresses itself
   function is_ind_reg;
      input [15:0] addr;
      input [15:0] a4;
      input [15:0] a5;
      input integer idx;
      begin
         is_ind_reg = (idx != 0) ? (addr == a5) : (addr == a4);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Per-indicator configuration registers
   genvar g;
   generate
      for (g = 0; g < NUM_IND; g = g + 1) begin : gen_cfg
         always @(posedge I_CORE_CLK or negedge I_RST_N) begin
            if (!I_RST_N) begin
               mask_low_ff[g] <= `MASK_RESET;
               mask_ext_ff[g] <= `MASK_RESET;
               blink_len_ff[g] <= `BLINK_LEN_RESET;
               func_ff[g] <= `FUNC_RESET;
               dis_ff[g] <= `DIS_RESET;
            end else if (I_REG_WR) begin
               if (is_ind_reg(I_REG_ADDR, `ADDR_IND4_MASK_LOW, `ADDR_IND5_MASK_LOW, g))
                  mask_low_ff[g] <= I_REG_WDATA;
               if (is_ind_reg(I_REG_ADDR, `ADDR_IND4_MASK_EXT, `ADDR_IND5_MASK_EXT, g))
                  mask_ext_ff[g] <= I_REG_WDATA;
               // Reserved upper bits are not stored; software keeps them itself
               if (is_ind_reg(I_REG_ADDR, `ADDR_IND4_BLINK, `ADDR_IND5_BLINK, g))
                  blink_len_ff[g] <= I_REG_WDATA[`BLINK_LEN_MSB:0];
               if (I_REG_ADDR == `ADDR_IND_CONTROL) begin
                  if (g == 0) begin
                     func_ff[g] <= I_REG_WDATA[`CTL_IND4_FUNC_LSB+1:`CTL_IND4_FUNC_LSB];
                     dis_ff[g] <= I_REG_WDATA[`CTL_IND4_DIS_BIT];
                  end else begin
                     func_ff[g] <= I_REG_WDATA[`CTL_IND5_FUNC_LSB+1:`CTL_IND5_FUNC_LSB];
                     dis_ff[g] <= I_REG_WDATA[`CTL_IND5_DIS_BIT];
                  end
               end
            end
         end

         // Any enabled source in either group makes the channel active
         wire src_active;
         assign src_active = |(mask_low_ff[g] & I_SOURCE_LOW) |
                             |(mask_ext_ff[g] & I_SOURCE_EXT);

         indicator_lamp u_lamp (
            .clk(I_CORE_CLK),
            .rst_n(I_RST_N),
            .slow_tick(O_SLOW_TICK),
            .src_active(src_active),
            .func_sel(func_ff[g]),
            .drive_disable(dis_ff[g]),
            .phase_len(blink_len_ff[g]),
            .pin_out_ff(O_IND_OUT[g]),
            .pin_oe_ff(O_IND_OE[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Slow-clock count registers; only the low byte of the high part exists
   always @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         slow_high_ff <= SLOW_CNT_RESET[23:16];
         slow_low_ff <= SLOW_CNT_RESET[15:0];
      end else if (I_REG_WR) begin
         if (I_REG_ADDR == `ADDR_SLOW_CNT_HIGH)
            slow_high_ff <= I_REG_WDATA[`SLOW_HIGH_MSB:0];
         if (I_REG_ADDR == `ADDR_SLOW_CNT_LOW)
            slow_low_ff <= I_REG_WDATA;
      end
   end

   assign slow_count = {slow_high_ff, slow_low_ff};

   ////////////////////////////////////////////////////////////////////////////
   // 10 ns step prescale; at 100 MHz this is every core cycle
   always @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N)
         ref_cnt_ff <= 8'h00;
      else if (ref_step)
         ref_cnt_ff <= 8'h00;
      else
         ref_cnt_ff <= ref_cnt_ff + 8'h01;
   end

   assign ref_step = (ref_cnt_ff == REF_CYCLES[7:0] - 8'h01);

   // Divider spans count plus one steps; a shrinking count wraps at once
   always @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         div_cnt_ff <= 24'h00_0000;
         O_SLOW_TICK <= 1'b0;
      end else begin
         O_SLOW_TICK <= 1'b0;
         if (ref_step) begin
            if (div_cnt_ff >= slow_count) begin
               div_cnt_ff <= 24'h00_0000;
               O_SLOW_TICK <= 1'b1;
            end else begin
               div_cnt_ff <= div_cnt_ff + 24'h00_0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; reserved and unmapped bits read as zero
   always @* begin
      nxt_rdata = 16'h0000;
      case (I_REG_ADDR)
         `ADDR_SLOW_CNT_LOW: nxt_rdata = slow_low_ff;
         `ADDR_SLOW_CNT_HIGH: nxt_rdata = {8'h00, slow_high_ff};
         `ADDR_IND4_MASK_LOW: nxt_rdata = mask_low_ff[0];
         `ADDR_IND5_MASK_LOW: nxt_rdata = mask_low_ff[1];
         `ADDR_IND4_MASK_EXT: nxt_rdata = mask_ext_ff[0];
         `ADDR_IND5_MASK_EXT: nxt_rdata = mask_ext_ff[1];
         `ADDR_IND4_BLINK: nxt_rdata = {12'h000, blink_len_ff[0]};
         `ADDR_IND5_BLINK: nxt_rdata = {12'h000, blink_len_ff[1]};
         `ADDR_IND_CONTROL: begin
            nxt_rdata[`CTL_IND4_FUNC_LSB+1:`CTL_IND4_FUNC_LSB] = func_ff[0];
            nxt_rdata[`CTL_IND4_DIS_BIT] = dis_ff[0];
            nxt_rdata[`CTL_IND5_FUNC_LSB+1:`CTL_IND5_FUNC_LSB] = func_ff[1];
            nxt_rdata[`CTL_IND5_DIS_BIT] = dis_ff[1];
         end
         default: nxt_rdata = 16'h0000;
      endcase
   end

   // Read data registered one cycle after the strobe, held until next read
   always @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_REG_RDATA <= 16'h0000;
         O_REG_RVALID <= 1'b0;
      end else begin
         O_REG_RVALID <= I_REG_RD;
         if (I_REG_RD)
            O_REG_RDATA <= nxt_rdata;
      end
   end

endmodule // indicator_blink_top

// >>> indicator_blink_top_tb_top.sv
/* Bench: register rows, source rows, drive disable, tick and blink timing.
   Assumes the lamp model and checker are compiled before it. */
`timescale 1ns/1ps
module indicator_blink_top_tb_top;
   typedef struct packed {logic w; logic [15:0] a, d, e;} row_t;
   logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, lvl5, rv, tick;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000, slo = 16'h0000, sex = 16'h0000, rdat, q;
   logic [1:0] iout, ioe;
   int err_count = 0, cmp_count = 0, n;
   // Reset values first, then write and read back
   row_t regs [18] = '{'{1'b0,16'hA82A,0,16'hFFFF}, '{1'b0,16'hA82B,0,16'h00FF},
      '{1'b0,16'hA837,0,16'h0004}, '{1'b0,16'hA83A,0,16'h0004}, '{1'b0,16'hA835,0,16'h0000},
      '{1'b0,16'hA838,0,16'h0000}, '{1'b0,16'hA8F2,0,16'h0000}, '{1'b0,16'hA8F3,0,16'h0000},
      '{1'b0,16'hA83B,0,16'h4800}, '{1'b1,16'hA82B,16'hAB12,16'h0012},
      '{1'b1,16'hA837,16'hFFF9,16'h0009}, '{1'b1,16'hA83A,16'h1230,16'h0000},
      '{1'b1,16'hA835,16'h0001,16'h0001}, '{1'b1,16'hA838,16'h00F0,16'h00F0},
      '{1'b1,16'hA8F2,16'h8000,16'h8000}, '{1'b1,16'hA8F3,16'h0001,16'h0001},
      '{1'b1,16'hA83B,16'hFFFF,16'h7E00}, '{1'b1,16'h0000,16'hFFFF,16'h0000}};
   // Source levels and expected {out, oe5, level5}
   row_t srcs [5] = '{'{1'b0,16'h0002,16'h0000,16'h0001}, '{1'b0,16'h0000,16'h0001,16'h0002},
      '{1'b0,16'h0000,16'h8000,16'h0005}, '{1'b0,16'h0011,16'h0000,16'h0006},
      '{1'b0,16'h0000,16'h7FFE,16'h0001}};
   always #5 clk = ~clk;
   indicator_blink_top i_indicator_blink_top (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr),
      .I_REG_WR(wr_s), .I_REG_WDATA(wdata), .I_REG_RD(rd_s), .I_SOURCE_LOW(slo), .I_SOURCE_EXT(sex),
      .O_REG_RDATA(rdat), .O_REG_RVALID(rv), .O_SLOW_TICK(tick), .O_IND_OUT(iout), .O_IND_OE(ioe));
   indicator_lamp_model i_indicator_lamp_model (.i_pin_out(iout[1]), .i_pin_oe(ioe[1]), .o_level(lvl5));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input [15:0] g, input [15:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input [15:0] a, input [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   // Answer pulse lasts one cycle, so it is looked for right after the read edge
   task automatic rd(input [15:0] a, output [15:0] d);
      int k;
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      for (k = 0; k < 4 && rv !== 1'b1; k++) @(posedge clk) #1;
      if (k == 4) begin
         err_count++;
         $display("[FAIL] %0t no read answer", $time);
         end_sim();
      end
      d = rdat;
   endtask
   // Counts changes of the tick or of indicator four over c cycles
   task automatic cnt(input bit w, input int c, output int k);
      logic p;
      p = w ? iout[0] : tick;
      k = 0;
      repeat (c) begin
         @(posedge clk);
         #1;
         if ((w ? iout[0] : tick) !== p) k++;
         p = w ? iout[0] : tick;
      end
   endtask
   task automatic drive(input [15:0] l, input [15:0] x);
      @(posedge clk);
      slo <= l;
      sex <= x;
      repeat (2) @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      foreach (regs[i]) begin
         if (regs[i].w) wr(regs[i].a, regs[i].d);
         rd(regs[i].a, q);
         chk(q, regs[i].e);
      end
      $display("test registers done");
      wr(16'hA83B, 16'h3400);
      foreach (srcs[i]) begin
         drive(srcs[i].a, srcs[i].d);
         chk({12'h000, iout, ioe[1], lvl5}, srcs[i].e);
      end
      $display("test sources done");
      wr(16'hA83B, 16'h7C00);
      drive(16'h0000, 16'h8001);
      chk({14'h0000, ioe}, 16'h0000);
      $display("test disable done");
      wr(16'hA82B, 16'h0000);
      wr(16'hA82A, 16'h0003);
      cnt(0, 40, n);
      chk(16'(n), 16'h0014);
      rd(16'hA837, q);
      wr(16'hA837, (q & 16'hFFF0) | 16'h0002);
      wr(16'hA83B, 16'h0200);
      cnt(1, 16, n);
      cnt(1, 64, n);
      chk(16'(n), 16'h0008);
      drive(16'h0000, 16'h0000);
      drive(16'h0000, 16'h8000);
      chk({15'h0000, iout[0]}, 16'h0001);
      cnt(1, 3, n);
      chk(16'(n), 16'h0000);
      $display("test blink done");
      // Mid-run reset: pins and registers fall back at once, not at the next edge
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk) #1;
      chk({10'h000, rv, tick, iout, ioe}, 16'h0000);
      @(posedge clk);
      rst_n <= 1'b1;
      rd(16'hA83B, q);
      chk(q, 16'h4800);
      rd(16'hA82B, q);
      chk(q, 16'h00FF);
      rd(16'hA837, q);
      chk(q, 16'h0004);
      $display("test reset done");
      // Off with the driver on for four, steady on five; {out, oe, level5}
      wr(16'hA8F2, 16'h8000);
      wr(16'hA8F3, 16'h0001);
      wr(16'hA83B, 16'h2000);
      drive(16'h0000, 16'h8001);
      chk({11'h000, iout, ioe, lvl5}, 16'h0017);
      $display("test modes done");
      end_sim();
   end
endmodule // indicator_blink_top_tb_top

// >>> indicator_lamp.v
/*
 * One indicator channel: blink phase timing and pin drive from the function
 * select, drive disable and source-active level.
 * Assumes slow_tick is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
`include "indicator_blink_defs.vh"

module indicator_lamp (
   input wire clk,
   input wire rst_n,
   input wire slow_tick,
   input wire src_active,
   input wire [1:0] func_sel,
   input wire drive_disable,
   input wire [3:0] phase_len,
   output reg pin_out_ff,
   output reg pin_oe_ff
);

   reg [3:0] phase_cnt_ff;
   reg phase_on_ff;
   reg [3:0] nxt_phase_cnt;
   reg nxt_phase_on;
   reg nxt_pin_out;
   reg nxt_pin_oe;
   wire [3:0] cnt_inc;
   wire phase_done;

   assign cnt_inc = phase_cnt_ff + 4'h1;
   // A zero length is treated as one tick so the lamp never freezes mid-phase
   assign phase_done = (cnt_inc >= phase_len);

   ////////////////////////////////////////////////////////////////////////////
   // Phase timing: restart lit on inactive source, toggle per elapsed count
   always @* begin
      nxt_phase_cnt = phase_cnt_ff;
      nxt_phase_on = phase_on_ff;
      if (!src_active) begin
         nxt_phase_cnt = 4'h0;
         nxt_phase_on = 1'b1;
      end else if (slow_tick) begin
         if (phase_done) begin
            nxt_phase_cnt = 4'h0;
            nxt_phase_on = ~phase_on_ff;
         end else begin
            nxt_phase_cnt = cnt_inc;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive per function select; open drain only pulls low while active
   always @* begin
      case (func_sel)
         `FUNC_OFF: begin
            nxt_pin_out = 1'b0;
            nxt_pin_oe = ~drive_disable;
         end
         `FUNC_BLINK: begin
            nxt_pin_out = src_active & phase_on_ff;
            nxt_pin_oe = ~drive_disable;
         end
         `FUNC_STEADY: begin
            nxt_pin_out = src_active;
            nxt_pin_oe = ~drive_disable;
         end
         `FUNC_OPEN_DRAIN: begin
            nxt_pin_out = 1'b0;
            nxt_pin_oe = src_active & ~drive_disable;
         end
         default: begin
            nxt_pin_out = 1'b0;
            nxt_pin_oe = 1'b0;
         end
      endcase
   end

   // Outputs are registered so the pads see no decode glitches
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_cnt_ff <= 4'h0;
         phase_on_ff <= 1'b1;
         pin_out_ff <= 1'b0;
         pin_oe_ff <= 1'b0;
      end else begin
         phase_cnt_ff <= nxt_phase_cnt;
         phase_on_ff <= nxt_phase_on;
         pin_out_ff <= nxt_pin_out;
         pin_oe_ff <= nxt_pin_oe;
      end
   end

endmodule // indicator_lamp

// >>> indicator_lamp_model.sv
/* Lamp model on one indicator pin with a pull-up.
   Assumes pin level and enable come from the block's pin registers. */
`timescale 1ns/1ps
module indicator_lamp_model (
   input wire i_pin_out,
   input wire i_pin_oe,
   output wire o_level
);
   // A released pin rises through the pull-up, so a stale value is never seen
   assign o_level = i_pin_oe ? i_pin_out : 1'b1;
endmodule // indicator_lamp_model
